// >>> common/tmr_pkg.sv
// Shared constants and types for the dual timer/counter block.
// Assumes a single system clock and an 8-bit register port.
package tmr_pkg;

    // Register offsets
    localparam logic [7:0] OFS_RUN_FLAGS = 8'h88;
    localparam logic [7:0] OFS_MODE = 8'h89;
    localparam logic [7:0] OFS_T0_LOW = 8'h8A;
    localparam logic [7:0] OFS_T1_LOW = 8'h8B;
    localparam logic [7:0] OFS_T0_HIGH = 8'h8C;
    localparam logic [7:0] OFS_T1_HIGH = 8'h8D;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h90;
    localparam logic [7:0] OFS_IRQ_EN = 8'h91;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h92;

    // Values after reset
    localparam logic [7:0] RST_RUN_FLAGS = 8'h00;
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_COUNT = 8'h00;
    localparam logic [1:0] RST_IRQ = 2'h0;
    localparam logic [7:0] RD_ZERO = 8'h00;

    // Field positions in the run/flags register
    localparam int POS_TF1 = 7;
    localparam int POS_TR1 = 6;
    localparam int POS_TF0 = 5;
    localparam int POS_TR0 = 4;

    // Field positions in the mode register
    localparam int POS_T0_CFG = 0;
    localparam int POS_T1_CFG = 4;

    // Mode encodings
    localparam logic [1:0] MODE_PRESCALE13 = 2'h0;
    localparam logic [1:0] MODE_CASCADE16 = 2'h1;
    localparam logic [1:0] MODE_RELOAD8 = 2'h2;
    localparam logic [1:0] MODE_SPLIT8 = 2'h3;

    // Counts of cycles and count limits
    localparam int INT_DIV_PERIODS = 12;
    localparam logic [4:0] PRE_FULL = 5'h1F;
    localparam logic [7:0] BYTE_FULL = 8'hFF;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic gate;
        logic count_source_sel;
        logic [1:0] mode;
    } tmr_cfg_t;

endpackage

// >>> rtl/pin_sync.sv
// Two-flop synchroniser for one pin, with falling-edge detection.
// Assumes the pin is asynchronous to i_clk_sys.
`timescale 1ns/1ps
module pin_sync
    import tmr_pkg::*;
(
    input wire logic i_clk_sys, // System clock
    input wire logic i_rst_b, // Async reset, active low
    input wire logic i_ce, // Clock enable
    input wire logic i_pin, // Raw pin
    output logic o_level, // Synchronised level
    output logic o_fall // One-cycle pulse on falling transition
);
    logic meta_ff;
    logic sync_ff;
    logic prev_ff;

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            prev_ff <= 1'b0;
        end else if (i_ce) begin
            meta_ff <= i_pin;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    assign o_level = sync_ff;
    assign o_fall = prev_ff & ~sync_ff;

    a_fall_shape: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        (i_ce && o_fall) |=> !o_fall)
        else $error("falling-edge pulse lasted more than one cycle");

endmodule // pin_sync

// >>> rtl/tick_div.sv
// Free-running divider that pulses once every DIV enabled clocks.
// Assumes a single clock domain and an enable that freezes it.
`timescale 1ns/1ps
module tick_div
    import tmr_pkg::*;
#(
    parameter int DIV = INT_DIV_PERIODS
) (
    input wire logic i_clk_sys, // System clock
    input wire logic i_rst_b, // Async reset, active low
    input wire logic i_ce, // Clock enable
    output logic o_tick // One-cycle pulse every DIV cycles
);
    localparam int CW = $clog2(DIV);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] cnt_ff;
    wire at_last = (cnt_ff == LAST);
    wire [CW-1:0] nxt_cnt = at_last ? '0 : cnt_ff + CW'(1);

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_ff <= '0;
        end else if (i_ce) begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign o_tick = at_last & i_ce;

    a_tick_period: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b || !i_ce)
        o_tick |-> ##12 o_tick)
        else $error("internal tick not spaced by twelve cycles");

endmodule // tick_div

// >>> rtl/dual_timer.sv
// Two 16-bit timer/counters with four modes, register port and interrupt.
// Assumes event and gate pins are asynchronous; vector acks are same-clock.
//
// Overview of operation
// - Timer mode counts once every twelve system clocks while enabled.
// - Counter mode counts each falling transition on the event pin.
// - Event pins sampled every clock; falling edges found from the samples.
// - Each timer holds its count in separate high and low byte registers.
// - Mode 0: high byte counts behind a 5-bit prescaler in the low byte.
// - Mode 1: low byte carries into high byte as one 16-bit counter.
// - Mode 2: low byte counts and reloads from the high byte on overflow.
// - Mode 3: timer 0 low byte is an 8-bit counter under timer 0 controls.
// - Mode 3: timer 0 high byte counts internal ticks under the timer 1 run bit.
// - Timer 1 in mode 3 holds its count as if stopped.
// - Gating set: count only while run bit and gate pin are high.
// - Source select 1 counts event pin; 0 counts the internal tick.
// - Each timer's run bit enables it, subject to gating.
// - Rollover of the valid count bits sets that timer's overflow flag, save timer 1 while timer 0 is in mode 3.
// - The mode 2 reload leaves the high byte unchanged.
// - Overflow flag cleared by vector acknowledge; software may set or clear.
// - Split high-byte timer uses timer 1 run bit and sets timer 1 flag.
`timescale 1ns/1ps
module dual_timer
    import tmr_pkg::*;
(
    input wire logic i_clk_sys, // System clock, 25 MHz
    input wire logic i_rst_b, // Async reset, active low
    input wire logic i_ce, // Clock enable, freezes all state when low
    input wire reg_req_t i_bus, // Register request
    output logic [7:0] o_rd_data, // Read data, cycle after read strobe
    input wire logic i_tmr0_event_pin, // Timer 0 event pin
    input wire logic i_tmr1_event_pin, // Timer 1 event pin
    input wire logic i_tmr0_level_enable_pin, // Timer 0 gate pin
    input wire logic i_tmr1_level_enable_pin, // Timer 1 gate pin
    input wire logic i_tmr0_vector_ack, // Timer 0 interrupt vectored
    input wire logic i_tmr1_vector_ack, // Timer 1 interrupt vectored
    output logic o_tmr0_overflow_flag, // Timer 0 overflow flag
    output logic o_tmr1_overflow_flag, // Timer 1 overflow flag
    output logic o_irq // Level interrupt
);
    logic [7:0] run_flags_ff;
    logic [7:0] mode_ff;
    logic [7:0] t0_low_ff;
    logic [7:0] t0_high_ff;
    logic [7:0] t1_low_ff;
    logic [7:0] t1_high_ff;
    logic [1:0] irq_stat_ff;
    logic [1:0] irq_en_ff;
    logic irq_ff;
    logic [7:0] rd_data_ff;

    logic tick;
    logic tmr0_level_enable_pin_lvl;
    logic tmr1_level_enable_pin_lvl;
    logic ev0_fall;
    logic ev1_fall;

    tick_div #(
        .DIV(INT_DIV_PERIODS)
    ) u_div (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_ce(i_ce),
        .o_tick(tick)
    );

    pin_sync u_ev0 (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_ce(i_ce),
        .i_pin(i_tmr0_event_pin),
        .o_level(),
        .o_fall(ev0_fall)
    );

    pin_sync u_ev1 (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_ce(i_ce),
        .i_pin(i_tmr1_event_pin),
        .o_level(),
        .o_fall(ev1_fall)
    );

    pin_sync u_tmr0_level_enable_pin (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_ce(i_ce),
        .i_pin(i_tmr0_level_enable_pin),
        .o_level(tmr0_level_enable_pin_lvl),
        .o_fall()
    );

    pin_sync u_tmr1_level_enable_pin (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_ce(i_ce),
        .i_pin(i_tmr1_level_enable_pin),
        .o_level(tmr1_level_enable_pin_lvl),
        .o_fall()
    );

    // Register decode
    wire wr_run_flags = i_bus.wr && (i_bus.addr == OFS_RUN_FLAGS);
    wire wr_mode = i_bus.wr && (i_bus.addr == OFS_MODE);
    wire wr_t0_low = i_bus.wr && (i_bus.addr == OFS_T0_LOW);
    wire wr_t0_high = i_bus.wr && (i_bus.addr == OFS_T0_HIGH);
    wire wr_t1_low = i_bus.wr && (i_bus.addr == OFS_T1_LOW);
    wire wr_t1_high = i_bus.wr && (i_bus.addr == OFS_T1_HIGH);
    wire wr_irq_en = i_bus.wr && (i_bus.addr == OFS_IRQ_EN);
    wire wr_irq_clr = i_bus.wr && (i_bus.addr == OFS_IRQ_CLR);

    // Per-timer configuration
    wire tmr_cfg_t cfg0 = tmr_cfg_t'(mode_ff[POS_T0_CFG +: 4]);
    wire tmr_cfg_t cfg1 = tmr_cfg_t'(mode_ff[POS_T1_CFG +: 4]);
    wire tmr0_run_bit = run_flags_ff[POS_TR0];
    wire tmr1_run_bit = run_flags_ff[POS_TR1];
    wire t0_split = (cfg0.mode == MODE_SPLIT8);
    wire t1_hold = (cfg1.mode == MODE_SPLIT8);

    // One step of a byte pair: {overflow, high, low}
    function automatic logic [16:0] step_count(
        input logic [1:0] mode,
        input logic [7:0] hi,
        input logic [7:0] lo
    );
        logic [16:0] res;
        res = {1'b0, hi, lo};
        case (mode)
            MODE_PRESCALE13: begin
                if (lo[4:0] == PRE_FULL) begin
                    res = {hi == BYTE_FULL, hi + 8'h01, lo[7:5], 5'h00};
                end else begin
                    res = {1'b0, hi, lo[7:5], lo[4:0] + 5'h01};
                end
            end
            MODE_CASCADE16: begin
                res = {1'b0, hi, lo} + 17'h00001;
            end
            MODE_RELOAD8: begin
                if (lo == BYTE_FULL) begin
                    res = {1'b1, hi, hi};
                end else begin
                    res = {1'b0, hi, lo + 8'h01};
                end
            end
            default: begin
                res = {lo == BYTE_FULL, hi, lo + 8'h01};
            end
        endcase
        return res;
    endfunction

    // Enables and count sources
    wire run0_en = tmr0_run_bit && (!cfg0.gate || tmr0_level_enable_pin_lvl);
    wire run1_en = tmr1_run_bit && (!cfg1.gate || tmr1_level_enable_pin_lvl) && !t1_hold;
    wire src0 = cfg0.count_source_sel ? ev0_fall : tick;
    wire src1 = cfg1.count_source_sel ? ev1_fall : tick;
    wire inc0 = run0_en && src0;
    wire inc1 = run1_en && src1;
    wire inc0_high = t0_split && tmr1_run_bit && tick;

    wire [16:0] step0 = step_count(cfg0.mode, t0_high_ff, t0_low_ff);
    wire [16:0] step1 = step_count(cfg1.mode, t1_high_ff, t1_low_ff);
    wire [7:0] t0_high_inc = t0_high_ff + 8'h01;

    // Overflow events; a byte write to the same timer suppresses them, in split mode only a write to the overflowing byte
    wire ovf0 = inc0 && step0[16] && !wr_t0_low && (t0_split || !wr_t0_high);
    wire ovf0_high = inc0_high && (t0_high_ff == BYTE_FULL) && !wr_t0_high;
    wire ovf1 = inc1 && step1[16] && !wr_t1_low && !wr_t1_high;
    wire set_tf0 = ovf0;
    wire set_tf1 = t0_split ? ovf0_high : ovf1;

    // Count next values, software write first
    wire [7:0] nxt_t0_low = wr_t0_low ? i_bus.wdata : (inc0 ? step0[7:0] : t0_low_ff);
    wire [7:0] t0_high_cnt = t0_split ? (inc0_high ? t0_high_inc : t0_high_ff)
                                      : (inc0 ? step0[15:8] : t0_high_ff);
    wire [7:0] nxt_t0_high = wr_t0_high ? i_bus.wdata : t0_high_cnt;
    wire [7:0] nxt_t1_low = wr_t1_low ? i_bus.wdata : (inc1 ? step1[7:0] : t1_low_ff);
    wire [7:0] nxt_t1_high = wr_t1_high ? i_bus.wdata : (inc1 ? step1[15:8] : t1_high_ff);

    // Run/flags: hardware set beats software clear and vector acknowledge
    wire [7:0] run_flags_base = wr_run_flags ? i_bus.wdata : run_flags_ff;
    wire nxt_tf0 = set_tf0 || (run_flags_base[POS_TF0] && !i_tmr0_vector_ack);
    wire nxt_tf1 = set_tf1 || (run_flags_base[POS_TF1] && !i_tmr1_vector_ack);
    wire [7:0] nxt_run_flags = {nxt_tf1, run_flags_base[6], nxt_tf0, run_flags_base[4:0]};
    wire [7:0] nxt_mode = wr_mode ? i_bus.wdata : mode_ff;

    // Interrupt status, enable and clear
    wire [1:0] irq_events = {set_tf1, set_tf0};
    wire [1:0] irq_clr_mask = wr_irq_clr ? i_bus.wdata[1:0] : 2'h0;
    wire [1:0] nxt_irq_stat = irq_events | (irq_stat_ff & ~irq_clr_mask);
    wire [1:0] nxt_irq_en = wr_irq_en ? i_bus.wdata[1:0] : irq_en_ff;
    wire nxt_irq = |(nxt_irq_stat & nxt_irq_en);

    // Read mux; unmapped and write-only offsets read zero
    wire [7:0] rd_mux =
        (i_bus.addr == OFS_RUN_FLAGS) ? run_flags_ff :
        (i_bus.addr == OFS_MODE) ? mode_ff :
        (i_bus.addr == OFS_T0_LOW) ? t0_low_ff :
        (i_bus.addr == OFS_T0_HIGH) ? t0_high_ff :
        (i_bus.addr == OFS_T1_LOW) ? t1_low_ff :
        (i_bus.addr == OFS_T1_HIGH) ? t1_high_ff :
        (i_bus.addr == OFS_IRQ_STAT) ? {6'h00, irq_stat_ff} :
        (i_bus.addr == OFS_IRQ_EN) ? {6'h00, irq_en_ff} : RD_ZERO;
    wire [7:0] nxt_rd_data = i_bus.rd ? rd_mux : RD_ZERO;

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            run_flags_ff <= RST_RUN_FLAGS;
            mode_ff <= RST_MODE;
        end else if (i_ce) begin
            run_flags_ff <= nxt_run_flags;
            mode_ff <= nxt_mode;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            t0_low_ff <= RST_COUNT;
            t0_high_ff <= RST_COUNT;
            t1_low_ff <= RST_COUNT;
            t1_high_ff <= RST_COUNT;
        end else if (i_ce) begin
            t0_low_ff <= nxt_t0_low;
            t0_high_ff <= nxt_t0_high;
            t1_low_ff <= nxt_t1_low;
            t1_high_ff <= nxt_t1_high;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            irq_stat_ff <= RST_IRQ;
            irq_en_ff <= RST_IRQ;
            irq_ff <= 1'b0;
            rd_data_ff <= RD_ZERO;
        end else if (i_ce) begin
            irq_stat_ff <= nxt_irq_stat;
            irq_en_ff <= nxt_irq_en;
            irq_ff <= nxt_irq;
            rd_data_ff <= nxt_rd_data;
        end
    end

    assign o_rd_data = rd_data_ff;
    assign o_irq = irq_ff;
    assign o_tmr0_overflow_flag = run_flags_ff[POS_TF0];
    assign o_tmr1_overflow_flag = run_flags_ff[POS_TF1];

    // Checks
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_b);

    wire no_wr0 = !wr_t0_low && !wr_t0_high;
    wire no_wr1 = !wr_t1_low && !wr_t1_high;

    sequence s_reload_cond;
        i_ce && cfg0.mode == MODE_RELOAD8 && inc0 && t0_low_ff == BYTE_FULL && no_wr0;
    endsequence

    sequence s_reload_done;
        t0_low_ff == $past(t0_high_ff) && $stable(t0_high_ff) && o_tmr0_overflow_flag;
    endsequence

    a_low_write_wins: assert property (
        (i_ce && wr_t0_low) |=> t0_low_ff == $past(i_bus.wdata))
        else $error("low byte write did not load");

    a_cascade_carry: assert property (
        (i_ce && cfg0.mode == MODE_CASCADE16 && inc0 && no_wr0
            && t0_low_ff == BYTE_FULL && t0_high_ff != BYTE_FULL)
        |=> t0_low_ff == 8'h00 && t0_high_ff == $past(t0_high_ff) + 8'h01)
        else $error("16-bit carry into high byte wrong");

    a_reload_keep: assert property (s_reload_cond |=> s_reload_done)
        else $error("auto-reload did not copy high byte or set flag");

    a_prescale_hold: assert property (
        (i_ce && cfg0.mode == MODE_PRESCALE13 && inc0 && no_wr0
            && t0_low_ff[4:0] != PRE_FULL)
        |=> $stable(t0_high_ff) && t0_low_ff[4:0] == $past(t0_low_ff[4:0]) + 5'h01)
        else $error("prescaler stepped high byte early");

    a_hold_mode3: assert property (
        (i_ce && t1_hold && no_wr1) |=> $stable(t1_low_ff) && $stable(t1_high_ff))
        else $error("timer 1 advanced in mode 3");

    a_gate_blocks: assert property (
        (i_ce && cfg0.gate && !tmr0_level_enable_pin_lvl && no_wr0 && !t0_split) |=> $stable(t0_low_ff))
        else $error("timer 0 counted with gate pin low");

    a_event_count: assert property (
        (i_ce && cfg0.count_source_sel && run0_en && ev0_fall && no_wr0
            && cfg0.mode == MODE_CASCADE16 && t0_low_ff != BYTE_FULL)
        |=> t0_low_ff == $past(t0_low_ff) + 8'h01)
        else $error("event edge not counted");

    a_ack_clears: assert property (
        (i_ce && i_tmr0_vector_ack && !set_tf0) |=> !o_tmr0_overflow_flag)
        else $error("vector acknowledge did not clear flag");

    a_split_flag: assert property (
        (i_ce && t0_split && tmr1_run_bit && tick && t0_high_ff == BYTE_FULL
            && !wr_t0_high)
        |=> o_tmr1_overflow_flag && t0_high_ff == 8'h00)
        else $error("split high byte overflow missed timer 1 flag");

    a_irq_follows: assert property (
        (i_ce && set_tf0 && (wr_irq_en ? i_bus.wdata[0] : irq_en_ff[0]))
        |=> o_irq ##1 (o_irq || !i_ce || $past(wr_irq_clr || wr_irq_en)))
        else $error("interrupt not raised for enabled overflow");

    a_tick_only: assert property (
        (i_ce && run1_en && !cfg1.count_source_sel && !tick && no_wr1)
        |=> $stable(t1_low_ff) && $stable(t1_high_ff))
        else $error("timer 1 advanced without an internal tick");

    a_run_off_hold: assert property (
        (i_ce && !tmr0_run_bit && no_wr0 && !t0_split)
        |=> $stable(t0_low_ff) && $stable(t0_high_ff))
        else $error("timer 0 advanced with its run bit clear");

    a_split_low: assert property (
        (i_ce && t0_split && inc0 && t0_low_ff == BYTE_FULL && !wr_t0_low)
        |=> t0_low_ff == 8'h00 && o_tmr0_overflow_flag)
        else $error("split low byte overflow wrong");

    a_flag_set_wins: assert property (
        (i_ce && set_tf0)
        |=> o_tmr0_overflow_flag)
        else $error("overflow lost against a same-cycle clear");

    a_status_sticky: assert property (
        (i_ce && set_tf1)
        |=> irq_stat_ff[1] && o_tmr1_overflow_flag)
        else $error("timer 1 overflow not recorded");

    a_rd_idle: assert property (
        (i_ce && !i_bus.rd)
        |=> o_rd_data == RD_ZERO)
        else $error("read data stood without a read");

endmodule // dual_timer

// >>> tb/pin_model.sv
// Model of the pins outside the timer block: two event pins, two gate pins.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/1ps
module pin_model (
    input wire logic i_clk_sys, // System clock
    output logic o_tmr0_event_pin, // Timer 0 event pin, idles high
    output logic o_tmr1_event_pin, // Timer 1 event pin, idles high
    output logic o_tmr0_level_enable_pin, // Timer 0 gate pin
    output logic o_tmr1_level_enable_pin // Timer 1 gate pin
);
    logic [1:0] ev_lvl;
    logic [1:0] gate_lvl;

    // Idle levels from time zero
    initial begin
        ev_lvl = 2'h3;
        gate_lvl = 2'h0;
    end

    assign o_tmr0_event_pin = ev_lvl[0];
    assign o_tmr1_event_pin = ev_lvl[1];
    assign o_tmr0_level_enable_pin = gate_lvl[0];
    assign o_tmr1_level_enable_pin = gate_lvl[1];

    // One falling edge, low level held three clocks, then six clocks high to settle
    task automatic fall(input int idx);
        @(posedge i_clk_sys);
        ev_lvl[idx] <= 1'b0;
        repeat (3) @(posedge i_clk_sys);
        ev_lvl[idx] <= 1'b1;
        repeat (6) @(posedge i_clk_sys);
    endtask

    // Gate level change, held long enough to pass the synchroniser
    task automatic set_gate(input int idx, input logic v);
        @(posedge i_clk_sys);
        gate_lvl[idx] <= v;
        repeat (4) @(posedge i_clk_sys);
    endtask
endmodule // pin_model

// >>> tb/tb_dual_timer.sv
// Self-checking bench for the dual timer/counter block.
// Assumes tmr_pkg, the design files and tb/pin_model.sv are compiled first.
`timescale 1ns/1ps
module tb_dual_timer
    import tmr_pkg::*;
();
    localparam reg_req_t BUS_IDLE = '0;
    logic clk_sys;
    logic rst_b;
    logic ce;
    reg_req_t bus;
    logic ack0;
    logic ack1;
    logic ev0;
    logic ev1;
    logic gt0;
    logic gt1;
    logic [7:0] rd_data;
    logic tf0;
    logic tf1;
    logic irq;
    int n_mismatch = 0;
    int checks_done = 0;
    logic [7:0] reg_ofs [9] = '{OFS_RUN_FLAGS, OFS_MODE, OFS_T0_LOW, OFS_T1_LOW, OFS_T0_HIGH,
        OFS_T1_HIGH, OFS_IRQ_STAT, OFS_IRQ_EN, 8'h95};

    always #20 clk_sys = ~clk_sys;

    dual_timer DUT (
        .i_clk_sys(clk_sys),
        .i_rst_b(rst_b),
        .i_ce(ce),
        .i_bus(bus),
        .o_rd_data(rd_data),
        .i_tmr0_event_pin(ev0),
        .i_tmr1_event_pin(ev1),
        .i_tmr0_level_enable_pin(gt0),
        .i_tmr1_level_enable_pin(gt1),
        .i_tmr0_vector_ack(ack0),
        .i_tmr1_vector_ack(ack1),
        .o_tmr0_overflow_flag(tf0),
        .o_tmr1_overflow_flag(tf1),
        .o_irq(irq)
    );

    pin_model PINS (
        .i_clk_sys(clk_sys),
        .o_tmr0_event_pin(ev0),
        .o_tmr1_event_pin(ev1),
        .o_tmr0_level_enable_pin(gt0),
        .o_tmr1_level_enable_pin(gt1)
    );

    task automatic finish_test();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus <= BUS_IDLE;
        #1;
        v = rd_data;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        rd(a, v);
        chk(v, exp);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus <= BUS_IDLE;
    endtask

    // Flags and interrupt as {tmr1 flag, tmr0 flag, irq}
    task automatic pins_chk(input logic [2:0] e);
        @(posedge clk_sys);
        #1;
        chk({5'h00, tf1, tf0, irq}, {5'h00, e});
    endtask

    task automatic ack_pulse(input int idx);
        @(posedge clk_sys);
        if (idx == 0) ack0 <= 1'b1;
        else ack1 <= 1'b1;
        @(posedge clk_sys);
        ack0 <= 1'b0;
        ack1 <= 1'b0;
    endtask

    // Two reads k internal periods apart, plus frz clocks with the enable low
    task automatic delta_chk(input logic [7:0] a, input int k, input logic [7:0] inc,
        input int frz);
        logic [7:0] v0;
        logic [7:0] v1;
        rd(a, v0);
        if (frz > 0) begin
            @(posedge clk_sys);
            ce <= 1'b0;
            repeat (frz) @(posedge clk_sys);
            ce <= 1'b1;
            repeat (INT_DIV_PERIODS * k - 3) @(posedge clk_sys);
        end else begin
            repeat (INT_DIV_PERIODS * k - 2) @(posedge clk_sys);
        end
        rd(a, v1);
        chk(8'(v1 - v0), inc);
    endtask

    initial begin
        repeat (6000) @(posedge clk_sys);
        n_mismatch++;
        finish_test();
    end

    initial begin
        clk_sys = 1'b0;
        rst_b = 1'b0;
        ce = 1'b1;
        bus = BUS_IDLE;
        ack0 = 1'b0;
        ack1 = 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        // Reset values, unmapped read, read data lasting one cycle
        foreach (reg_ofs[i]) begin
            rd_chk(reg_ofs[i], RST_MODE);
        end
        @(posedge clk_sys);
        #1;
        chk(rd_data, RD_ZERO);
        // Byte registers, back-to-back writes then reads
        for (int i = 0; i < 4; i++) wr(8'(OFS_T0_LOW + i), 8'(8'hA1 + i));
        for (int i = 0; i < 4; i++) rd_chk(8'(OFS_T0_LOW + i), 8'(8'hA1 + i));
        wr(OFS_MODE, 8'hA5);
        rd_chk(OFS_MODE, 8'hA5);
        // Timer 0, 13-bit counter: prescaler carry, then full rollover
        wr(OFS_MODE, 8'h04);
        wr(OFS_T0_LOW, 8'hFF);
        wr(OFS_T0_HIGH, 8'h00);
        wr(OFS_RUN_FLAGS, 8'h10);
        PINS.fall(0);
        rd_chk(OFS_T0_LOW, 8'hE0);
        rd_chk(OFS_T0_HIGH, 8'h01);
        wr(OFS_T0_LOW, 8'h1F);
        wr(OFS_T0_HIGH, 8'hFF);
        PINS.fall(0);
        rd_chk(OFS_T0_HIGH, 8'h00);
        pins_chk(3'b010);
        rd_chk(OFS_IRQ_STAT, 8'h01);
        // Run bit off: flag cleared by software, no counting
        wr(OFS_RUN_FLAGS, 8'h00);
        PINS.fall(0);
        rd_chk(OFS_T0_LOW, 8'h00);
        pins_chk(3'b000);
        // Gating by the level pin
        wr(OFS_MODE, 8'h0C);
        wr(OFS_RUN_FLAGS, 8'h10);
        PINS.fall(0);
        rd_chk(OFS_T0_LOW, 8'h00);
        PINS.set_gate(0, 1'b1);
        PINS.fall(0);
        rd_chk(OFS_T0_LOW, 8'h01);
        PINS.set_gate(0, 1'b0);
        // Auto-reload, high byte kept
        wr(OFS_MODE, 8'h06);
        wr(OFS_T0_LOW, 8'hFF);
        wr(OFS_T0_HIGH, 8'h40);
        PINS.fall(0);
        rd_chk(OFS_T0_LOW, 8'h40);
        rd_chk(OFS_T0_HIGH, 8'h40);
        pins_chk(3'b010);
        PINS.fall(0);
        rd_chk(OFS_T0_LOW, 8'h41);
        // Timer 0, 16-bit event counter with carry
        wr(OFS_MODE, 8'h05);
        wr(OFS_T0_LOW, 8'hFE);
        PINS.fall(0);
        PINS.fall(0);
        rd_chk(OFS_T0_LOW, 8'h00);
        rd_chk(OFS_T0_HIGH, 8'h41);
        // Interrupt enable, clear, vector acknowledge, software set
        rd_chk(OFS_IRQ_STAT, 8'h01);
        wr(OFS_IRQ_EN, 8'h01);
        pins_chk(3'b011);
        wr(OFS_IRQ_CLR, 8'h01);
        pins_chk(3'b010);
        rd_chk(OFS_IRQ_STAT, 8'h00);
        ack_pulse(0);
        pins_chk(3'b000);
        wr(OFS_RUN_FLAGS, 8'h30);
        pins_chk(3'b010);
        wr(OFS_RUN_FLAGS, 8'h10);
        wr(OFS_IRQ_EN, 8'h00);
        pins_chk(3'b000);
        // Timer 1, 16-bit counter with carry and rollover
        wr(OFS_MODE, 8'h50);
        wr(OFS_T1_LOW, 8'hFF);
        wr(OFS_T1_HIGH, 8'hFF);
        wr(OFS_RUN_FLAGS, 8'h40);
        PINS.fall(1);
        rd_chk(OFS_T1_LOW, 8'h00);
        rd_chk(OFS_T1_HIGH, 8'h00);
        pins_chk(3'b100);
        rd_chk(OFS_IRQ_STAT, 8'h02);
        wr(OFS_IRQ_CLR, 8'h02);
        rd_chk(OFS_IRQ_STAT, 8'h00);
        ack_pulse(1);
        pins_chk(3'b000);
        // Timer 1 on the internal divided clock
        wr(OFS_MODE, 8'h10);
        wr(OFS_T1_LOW, 8'h00);
        delta_chk(OFS_T1_LOW, 10, 8'h0A, 0);
        // Split mode: timer 0 two bytes, timer 1 held
        wr(OFS_RUN_FLAGS, 8'h00);
        wr(OFS_T1_LOW, 8'h77);
        wr(OFS_T1_HIGH, 8'h66);
        wr(OFS_MODE, 8'h37);
        wr(OFS_T0_LOW, 8'hFF);
        wr(OFS_T0_HIGH, 8'h10);
        wr(OFS_IRQ_EN, 8'h03);
        wr(OFS_RUN_FLAGS, 8'h50);
        PINS.fall(0);
        rd_chk(OFS_T0_LOW, 8'h00);
        pins_chk(3'b011);
        delta_chk(OFS_T0_HIGH, 5, 8'h05, 0);
        // Enable low for 48 clocks: divider and counts frozen
        delta_chk(OFS_T0_HIGH, 2, 8'h02, 48);
        rd_chk(OFS_T1_LOW, 8'h77);
        rd_chk(OFS_T1_HIGH, 8'h66);
        wr(OFS_RUN_FLAGS, 8'h50);
        wr(OFS_IRQ_CLR, 8'h01);
        wr(OFS_T0_HIGH, 8'hFF);
        repeat (30) @(posedge clk_sys);
        pins_chk(3'b101);
        finish_test();
    end
endmodule // tb_dual_timer
